// ---- hw/btm_addrgen.sv ----
// data address former: direct page form or indirect pointer form
`timescale 1ns/1ps
module btm_addrgen
  import btm_pkg::*;
(
  input  wire logic              indirect,
  input  wire logic [8:0]        page,
  input  wire logic [6:0]        offset,
  input  wire logic [15:0]       pointer,
  output logic [15:0]            addr
);
  // page pointer joined with seven low bits gives 16-bit address
  always_comb
  begin
    if (indirect)
      addr = pointer;
    else
      addr = {page, offset};
  end
endmodule

// ---- hw/btm_bitsel.sv ----
// bit selection for both bit-test forms
`timescale 1ns/1ps
module btm_bitsel
  import btm_pkg::*;
(
  input  wire logic [15:0]      data_word,
  input  wire logic [3:0]       code,
  output logic                  bit_out
);
  // code 0 picks the most significant bit
  always_comb
  begin
    bit_out = data_word[4'(WORD_MSB) - code];
  end
endmodule

// ---- hw/btm_exec.sv ----
// execution unit for bit tests and block moves of the processor core
//
// Behaviour
// - bit tests finish in one cycle plus waits and memory-block conflicts (here three cycles from start to done)
// - immediate bit test copies bit (15 - code) into the test flag; indirect sets next pointer
// - register bit test uses four low bits of temporary register as selector
// - data move pairs long immediate with direct or indirect, either side
// - repeated move transfers repeat count plus one words
// - repeated move loads immediate into program counter, advancing it each word
// - indirect operand updates every word; direct operand stays fixed
// - source and destination may be on chip, off chip, or mixed
// - interrupts held off during repeated move; further words one cycle each (here three each, four when indirect)
// - save pc on micro stack, load immediate, copy, update, step, restore
// - single data moves take three cycles (here six from start to done); shared single-access block adds one
// - program-to-data move reads program memory at immediate; data destination
// - repeated program-to-data move transfers repeat count plus one words
`timescale 1ns/1ps
module btm_exec
(
  input  wire logic                CLK_SYS,
  input  wire logic                RESETN,
  input  wire logic                START,
  input  wire btm_pkg::btm_op_t    OP,
  input  wire logic                REPEATED,
  input  wire logic [15:0]         REPEAT_COUNT,
  input  wire logic                DIRECTION,
  input  wire logic                INDIRECT,
  input  wire logic [6:0]          DIRECT_OFFSET,
  input  wire logic [8:0]          PAGE_POINTER,
  input  wire logic [3:0]          BIT_CODE,
  input  wire logic [15:0]         TEMP_OPERAND,
  input  wire logic [15:0]         LONG_IMMEDIATE,
  input  wire logic [15:0]         AUX_POINTER,
  input  wire logic [2:0]          NEXT_AUX,
  input  wire logic                SET_NEXT_AUX,
  input  wire logic [15:0]         PC_IN,
  input  wire logic                SAME_SINGLE_ACCESS_RAM,
  input  wire logic                MEM_READY,
  input  wire logic [15:0]         MEM_RDATA,
  output logic                     BUSY,
  output logic                     DONE,
  output logic                     TEST_FLAG,
  output logic                     TEST_FLAG_WE,
  output logic [2:0]               AUX_SELECT,
  output logic                     AUX_SELECT_WE,
  output logic                     AUX_UPDATE,
  output logic                     INT_HOLD,
  output logic [15:0]              PC_OUT,
  output logic                     PC_WE,
  output logic [15:0]              STACK_WORD,
  output logic                     STACK_PUSH,
  output logic                     MEM_RD,
  output logic                     MEM_RD_PROG,
  output logic                     MEM_WR,
  output logic [15:0]              MEM_ADDR,
  output logic [15:0]              MEM_WDATA
);
  import btm_pkg::*;

  // ---------------------------------------------------------------
  // state record
  // ---------------------------------------------------------------
  typedef struct packed {
    btm_state_t  state;
    btm_op_t     op;
    logic        rep;
    logic        dir;
    logic        ind;
    logic        extra;
    logic [15:0] count;
    logic [15:0] daddr;
    logic [15:0] pc;
    logic [15:0] saved_pc;
    logic        busy;
    logic        done;
    logic        tflag;
    logic        tflag_we;
    logic [2:0]  auxsel;
    logic        auxsel_we;
    logic        aux_upd;
    logic        int_hold;
    logic [15:0] pc_out;
    logic        pc_we;
    logic [15:0] stack_word;
    logic        stack_push;
    logic        rd;
    logic        rd_prog;
    logic        wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } btm_ctx_t;

  btm_ctx_t    cur_ff;
  btm_ctx_t    nxt_cur;
  logic        rst_meta_ff;
  logic        rst_sync_ff;
  logic [15:0] dir_addr;
  logic [3:0]  sel_code;
  logic        sel_bit;

  // ---------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge RESETN)
  begin
    if (!RESETN)
    begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  btm_addrgen u_addrgen (
    .indirect (INDIRECT),
    .page     (PAGE_POINTER),
    .offset   (DIRECT_OFFSET),
    .pointer  (AUX_POINTER),
    .addr     (dir_addr)
  );

  // selector from opcode or low nibble of temporary register
  assign sel_code = (cur_ff.op == OP_BIT_TEMPORARY_OPERAND_REG) ? TEMP_OPERAND[SEL_W-1:0] : BIT_CODE;

  btm_bitsel u_bitsel (
    .data_word (MEM_RDATA),
    .code      (sel_code),
    .bit_out   (sel_bit)
  );

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_cur            = cur_ff;
    nxt_cur.tflag_we   = 1'b0;
    nxt_cur.auxsel_we  = 1'b0;
    nxt_cur.aux_upd    = 1'b0;
    nxt_cur.pc_we      = 1'b0;
    nxt_cur.stack_push = 1'b0;
    nxt_cur.rd         = 1'b0;
    nxt_cur.rd_prog    = 1'b0;
    nxt_cur.wr         = 1'b0;
    nxt_cur.done       = 1'b0;
    case (cur_ff.state)
      ST_IDLE:
      begin
        if (START)
        begin
          nxt_cur.op    = OP;
          nxt_cur.rep   = REPEATED;
          nxt_cur.count = REPEAT_COUNT;
          nxt_cur.dir   = (OP == OP_BLOCK_MOVE_PROGRAM_TO_DATA) ? DIR_IMM_SRC : DIRECTION;
          nxt_cur.ind   = INDIRECT;
          nxt_cur.daddr = dir_addr;
          nxt_cur.extra = SAME_SINGLE_ACCESS_RAM;
          nxt_cur.busy  = 1'b1;
          if (OP == OP_BIT_IMM || OP == OP_BIT_TEMPORARY_OPERAND_REG)
          begin
            // bit test: one read, flag taken on ready
            nxt_cur.rd    = 1'b1;
            nxt_cur.addr  = dir_addr;
            nxt_cur.state = ST_READ;
          end
          else
          begin
            // save advanced pc, park immediate in pc
            nxt_cur.stack_word = PC_IN + 16'h0001;
            nxt_cur.stack_push = 1'b1;
            nxt_cur.saved_pc   = PC_IN + 16'h0001;
            nxt_cur.pc         = LONG_IMMEDIATE;
            nxt_cur.pc_out     = LONG_IMMEDIATE;
            nxt_cur.pc_we      = 1'b1;
            nxt_cur.int_hold   = REPEATED;
            nxt_cur.state      = ST_SETUP;
          end
        end
      end
      ST_SETUP:
      begin
        // once a pointer update has settled, issue the source read
        if (!cur_ff.aux_upd)
        begin
          if (cur_ff.ind)
            nxt_cur.daddr = AUX_POINTER;
          nxt_cur.rd      = 1'b1;
          nxt_cur.rd_prog = (cur_ff.op == OP_BLOCK_MOVE_PROGRAM_TO_DATA);
          nxt_cur.addr    = (cur_ff.dir == DIR_IMM_SRC) ? cur_ff.pc : nxt_cur.daddr;
          nxt_cur.state   = ST_READ;
        end
      end
      ST_READ:
      begin
        if (!MEM_READY)
        begin
          nxt_cur.rd      = cur_ff.rd; // wait states stretch the access
          nxt_cur.rd_prog = cur_ff.rd_prog;
        end
        else if (cur_ff.op == OP_BIT_IMM || cur_ff.op == OP_BIT_TEMPORARY_OPERAND_REG)
        begin
          nxt_cur.tflag    = sel_bit;
          nxt_cur.tflag_we = 1'b1;
          nxt_cur.auxsel    = NEXT_AUX;
          nxt_cur.auxsel_we = cur_ff.ind && SET_NEXT_AUX;
          nxt_cur.aux_upd   = cur_ff.ind;
          nxt_cur.state     = ST_DONE;
        end
        else
        begin
          // write the copied word to the destination
          nxt_cur.wdata = MEM_RDATA;
          nxt_cur.wr    = 1'b1;
          nxt_cur.addr  = (cur_ff.dir == DIR_IMM_SRC) ? cur_ff.daddr : cur_ff.pc;
          nxt_cur.state = ST_WRITE;
        end
      end
      ST_WRITE:
      begin
        if (!MEM_READY)
          nxt_cur.wr = 1'b1;
        else
        begin
          // indirect operand updated each word, direct stays fixed
          nxt_cur.aux_upd = cur_ff.ind;
          nxt_cur.pc      = cur_ff.pc + 16'h0001;
          nxt_cur.pc_out  = cur_ff.pc + 16'h0001;
          nxt_cur.pc_we   = 1'b1;
          if (cur_ff.rep && cur_ff.count != 16'h0000)
          begin
            nxt_cur.count = cur_ff.count - 16'h0001;
            nxt_cur.state = ST_SETUP;
          end
          else
            nxt_cur.state = ST_STEP;
        end
      end
      ST_STEP:
      begin
        // restore the saved program counter
        nxt_cur.pc_out   = cur_ff.saved_pc;
        nxt_cur.pc_we    = 1'b1;
        nxt_cur.int_hold = 1'b0;
        nxt_cur.state    = ST_DONE;
      end
      ST_DONE:
      begin
        if (cur_ff.extra)
          nxt_cur.extra = 1'b0;
        else
        begin
          nxt_cur.busy  = 1'b0;
          nxt_cur.done  = 1'b1;
          nxt_cur.state = ST_IDLE;
        end
      end
      default:
        nxt_cur.state = ST_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      cur_ff          <= '0;
      cur_ff.pc       <= PC_RST;
      cur_ff.saved_pc <= PC_RST;
      cur_ff.wdata    <= WORD_RST;
    end
    else
      cur_ff <= nxt_cur;
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign BUSY          = cur_ff.busy;
  assign DONE          = cur_ff.done;
  assign TEST_FLAG     = cur_ff.tflag;
  assign TEST_FLAG_WE  = cur_ff.tflag_we;
  assign AUX_SELECT    = cur_ff.auxsel;
  assign AUX_SELECT_WE = cur_ff.auxsel_we;
  assign AUX_UPDATE    = cur_ff.aux_upd;
  assign INT_HOLD      = cur_ff.int_hold;
  assign PC_OUT        = cur_ff.pc_out;
  assign PC_WE         = cur_ff.pc_we;
  assign STACK_WORD    = cur_ff.stack_word;
  assign STACK_PUSH    = cur_ff.stack_push;
  assign MEM_RD        = cur_ff.rd;
  assign MEM_RD_PROG   = cur_ff.rd_prog;
  assign MEM_WR        = cur_ff.wr;
  assign MEM_ADDR      = cur_ff.addr;
  assign MEM_WDATA     = cur_ff.wdata;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_HOLD_WHEN_REP: assert property (@(posedge CLK_SYS) disable iff (!rst_sync_ff)
    (cur_ff.state == ST_IDLE && START && REPEATED && OP == OP_BLOCK_MOVE_DATA_TO_DATA) |=> INT_HOLD)
    else $error("interrupts not held for repeated move");
  AST_PUSH_THEN_PC: assert property (@(posedge CLK_SYS) disable iff (!rst_sync_ff)
    STACK_PUSH |-> (PC_WE && PC_OUT == cur_ff.pc))
    else $error("pc not loaded with push");
  AST_FLAG_AFTER_READ: assert property (@(posedge CLK_SYS) disable iff (!rst_sync_ff)
    (TEST_FLAG_WE && !cur_ff.extra) |=> DONE)
    else $error("bit test did not finish");
  AST_FLAG_SHARED: assert property (@(posedge CLK_SYS) disable iff (!rst_sync_ff)
    (TEST_FLAG_WE && cur_ff.extra) |=> !DONE ##1 DONE)
    else $error("shared block bit test did not take one more cycle");
  AST_REP_WORDS: assert property (@(posedge CLK_SYS) disable iff (!rst_sync_ff)
    (cur_ff.state == ST_WRITE && MEM_READY && cur_ff.rep && cur_ff.count != 16'h0000)
      |=> cur_ff.state == ST_SETUP)
    else $error("repeat ended early");
  AST_PC_STEP: assert property (@(posedge CLK_SYS) disable iff (!rst_sync_ff)
    (cur_ff.state == ST_WRITE && MEM_READY) |=> PC_OUT == $past(cur_ff.pc) + 16'h0001)
    else $error("pc did not advance by one");
  AST_RESTORE: assert property (@(posedge CLK_SYS) disable iff (!rst_sync_ff)
    (cur_ff.state == ST_STEP) |=> (PC_WE && PC_OUT == cur_ff.saved_pc && !INT_HOLD))
    else $error("pc not restored");
  AST_PROG_SRC: assert property (@(posedge CLK_SYS) disable iff (!rst_sync_ff)
    (MEM_RD_PROG) |-> (cur_ff.op == OP_BLOCK_MOVE_PROGRAM_TO_DATA && MEM_ADDR == cur_ff.pc))
    else $error("program read not at pc");
  AST_DIRECT_FIXED: assert property (@(posedge CLK_SYS) disable iff (!rst_sync_ff)
    (cur_ff.busy && !cur_ff.ind && cur_ff.state != ST_IDLE) |=> $stable(cur_ff.daddr))
    else $error("direct address moved");
endmodule

// ---- pkg/btm_pkg.sv ----
// constants and types for the bit-test and block-move execution unit
package btm_pkg;
  // operation codes presented on the start port
  typedef enum logic [2:0] {
    OP_BIT_IMM  = 3'b000,
    OP_BIT_TEMPORARY_OPERAND_REG = 3'b001,
    OP_BLOCK_MOVE_DATA_TO_DATA     = 3'b010,
    OP_BLOCK_MOVE_PROGRAM_TO_DATA     = 3'b011
  } btm_op_t;

  // direction of a data-to-data move (which side holds the immediate)
  localparam logic DIR_IMM_SRC = 1'b0;
  localparam logic DIR_IMM_DST = 1'b1;

  // field positions
  localparam int DIRECT_LSB_W  = 7;
  localparam int SEL_W         = 4;
  localparam int WORD_MSB      = 15;
  localparam int AR_SEL_W      = 3;

  // reset values
  localparam logic [15:0] PC_RST   = 16'h0000;
  localparam logic [15:0] WORD_RST = 16'h0000;

  // timing: base cycles of single forms (on-chip, no conflict)
  localparam logic [3:0] BIT_BASE_CYC  = 4'h1;
  localparam logic [3:0] MOVE_BASE_CYC = 4'h3;
  localparam logic [3:0] SINGLE_ACCESS_RAM_EXTRA   = 4'h1;

  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SETUP = 3'b001,
    ST_READ  = 3'b010,
    ST_WRITE = 3'b011,
    ST_STEP  = 3'b100,
    ST_DONE  = 3'b101
  } btm_state_t;
endpackage

// ---- verif/bit_test_and_block_move_exec_tb_top.sv ----
// self-checking bench for the bit-test and block-move execution unit
`timescale 1ns/1ps
module bit_test_and_block_move_exec_tb_top;
  import btm_pkg::*;
  typedef struct {btm_op_t op; logic [3:0] c; logic [15:0] t, w; logic i, e;} btm_brow_t;
  typedef struct {btm_op_t op; logic r; logic [15:0] n; logic d, i; logic [1:0] ws;} btm_mrow_t;
  logic        CLK_SYS, RESETN, START, REPEATED, DIRECTION, INDIRECT, SET_NEXT_AUX;
  logic        SAME_SINGLE_ACCESS_RAM, MEM_READY, BUSY, DONE, TEST_FLAG, TEST_FLAG_WE, AUX_SELECT_WE;
  logic        AUX_UPDATE, INT_HOLD, PC_WE, STACK_PUSH, MEM_RD, MEM_RD_PROG, MEM_WR;
  btm_op_t     OP;
  logic [15:0] REPEAT_COUNT, TEMP_OPERAND, LONG_IMMEDIATE, AUX_POINTER, PC_IN, MEM_RDATA;
  logic [15:0] PC_OUT, STACK_WORD, MEM_ADDR, MEM_WDATA, ra, sw;
  logic [6:0]  DIRECT_OFFSET;
  logic [8:0]  PAGE_POINTER;
  logic [3:0]  BIT_CODE;
  logic [2:0]  NEXT_AUX, AUX_SELECT, asel;
  logic [1:0]  waits;
  logic        flag, hold_bad;
  int          n_fail, checks, cyc, ndone, t, nd0;
  logic [15:0] wa[$], wd[$], pcq[$];
  btm_brow_t   br[6] = '{'{OP_BIT_IMM, 4'h0, 16'h0000, 16'h8000, 1, 1},
                         '{OP_BIT_IMM, 4'hF, 16'h0000, 16'h0001, 0, 1},
                         '{OP_BIT_IMM, 4'h1, 16'h0000, 16'hBFFF, 0, 0},
                         '{OP_BIT_TEMPORARY_OPERAND_REG, 4'h0, 16'hFFF1, 16'h4000, 0, 1},
                         '{OP_BIT_TEMPORARY_OPERAND_REG, 4'h0, 16'h000F, 16'hFFFE, 1, 0},
                         '{OP_BIT_TEMPORARY_OPERAND_REG, 4'hB, 16'h1234, 16'h0800, 0, 1}};
  btm_mrow_t   mr[7] = '{'{OP_BLOCK_MOVE_DATA_TO_DATA, 0, 16'h0000, 0, 0, 0}, '{OP_BLOCK_MOVE_DATA_TO_DATA, 1, 16'h0003, 1, 1, 2},
                         '{OP_BLOCK_MOVE_DATA_TO_DATA, 1, 16'h0000, 0, 1, 0}, '{OP_BLOCK_MOVE_DATA_TO_DATA, 1, 16'h0002, 1, 0, 1},
                         '{OP_BLOCK_MOVE_PROGRAM_TO_DATA, 0, 16'h0000, 0, 0, 0}, '{OP_BLOCK_MOVE_PROGRAM_TO_DATA, 1, 16'h0004, 0, 1, 1},
                         '{OP_BLOCK_MOVE_PROGRAM_TO_DATA, 1, 16'h0001, 0, 0, 0}};

  btm_exec btm_exec_i (.*);
  btm_mem_model btm_mem_model_i (.clk(CLK_SYS), .rd(MEM_RD), .rd_prog(MEM_RD_PROG),
    .wr(MEM_WR), .addr(MEM_ADDR), .wdata(MEM_WDATA), .waits(waits), .ready(MEM_READY),
    .rdata(MEM_RDATA));

  // clock
  initial
  begin
    CLK_SYS = 1'b0;
    forever #5 CLK_SYS = ~CLK_SYS;
  end

  // record bus traffic and pulses, step the aux register on each update
  always @(posedge CLK_SYS)
  begin
    cyc <= cyc + 1;
    if (DONE)
      ndone <= ndone + 1;
    if (MEM_WR && MEM_READY)
    begin
      wa.push_back(MEM_ADDR);
      wd.push_back(MEM_WDATA);
      if (INT_HOLD !== REPEATED)
        hold_bad <= 1'b1;
    end
    if ((MEM_RD | MEM_RD_PROG) && MEM_READY)
      ra <= MEM_ADDR;
    if (PC_WE)
      pcq.push_back(PC_OUT);
    if (STACK_PUSH)
      sw <= STACK_WORD;
    if (TEST_FLAG_WE)
      flag <= TEST_FLAG;
    if (AUX_SELECT_WE)
      asel <= AUX_SELECT;
    if (AUX_UPDATE)
      AUX_POINTER <= AUX_POINTER + 16'h0001;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(string nm, logic [15:0] s, logic [15:0] e);
    checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // wait idle, pulse start, count cycles until done
  task automatic run(output int c);
    int k;
    for (k = 0; k < 100 && (BUSY !== 1'b0 || DONE !== 1'b0); k++) @(negedge CLK_SYS);
    @(posedge CLK_SYS);
    START <= 1'b1;
    @(posedge CLK_SYS);
    START <= 1'b0;
    for (k = 1; k < 400 && DONE !== 1'b1; k++) @(negedge CLK_SYS);
    c = k - 1;
    chk("done", DONE, 1);
  endtask

  task automatic bt(btm_brow_t b);
    @(posedge CLK_SYS);
    OP <= b.op;
    BIT_CODE <= b.c;
    TEMP_OPERAND <= b.t;
    INDIRECT <= b.i;
    SET_NEXT_AUX <= b.i;
    AUX_POINTER <= 16'h0400;
    btm_mem_model_i.mem[b.i ? 16'h0400 : 16'h0310] = b.w;
    flag = 1'bx;
    asel = 3'bxxx;
    run(t);
    chk("flag", flag, b.e);
    chk("addr", ra, b.i ? 16'h0400 : 16'h0310);
    chk("cycles", t, 3 + SAME_SINGLE_ACCESS_RAM);
    if (b.i)
      chk("aux_sel", asel, 3'h5);
  endtask

  task automatic mv(btm_mrow_t m);
    int n;
    int k;
    logic [15:0] o, s, d;
    @(posedge CLK_SYS);
    OP <= m.op;
    {REPEATED, REPEAT_COUNT, DIRECTION, INDIRECT, waits} <= {m.r, m.n, m.d, m.i, m.ws};
    AUX_POINTER <= 16'h0500;
    btm_mem_model_i.mem.delete();
    wa.delete();
    wd.delete();
    pcq.delete();
    hold_bad = 1'b0;
    run(t);
    n = m.r ? m.n + 1 : 1;
    chk("words", wa.size(), n);
    for (k = 0; k < n && k < wa.size(); k++)
    begin
      o = m.i ? 16'h0500 + k : 16'h0310;
      s = (m.op == OP_BLOCK_MOVE_DATA_TO_DATA && m.d) ? o : 16'h0800 + k;
      d = (m.op == OP_BLOCK_MOVE_DATA_TO_DATA && m.d) ? 16'h0800 + k : o;
      chk("waddr", wa[k], d);
      chk("wdata", wd[k], s ^ (m.op == OP_BLOCK_MOVE_PROGRAM_TO_DATA ? 16'h5A5A : 16'hC3A5));
      if (k + 1 < pcq.size())
        chk("pc_step", pcq[k], 16'h0800 + k);
    end
    chk("pc_writes", pcq.size(), n + 2);
    chk("pc_back", pcq[pcq.size() - 1], 16'h0121);
    chk("stack", sw, 16'h0121);
    chk("hold", hold_bad, 0);
    if (!m.r && m.ws == 0)
      chk("cycles", t, 6 + SAME_SINGLE_ACCESS_RAM);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    {RESETN, START, REPEATED, DIRECTION, INDIRECT, SET_NEXT_AUX, SAME_SINGLE_ACCESS_RAM} = 7'h00;
    OP = OP_BIT_IMM;
    {BIT_CODE, TEMP_OPERAND, REPEAT_COUNT, waits} = '0;
    {n_fail, checks, cyc, ndone} = '0;
    LONG_IMMEDIATE = 16'h0800;
    AUX_POINTER = 16'h0400;
    PC_IN = 16'h0120;
    NEXT_AUX = 3'h5;
    PAGE_POINTER = 9'h006;
    DIRECT_OFFSET = 7'h10;
    repeat (6) @(posedge CLK_SYS);
    RESETN <= 1'b1;
    repeat (3) @(posedge CLK_SYS);
    foreach (br[j])
    begin
      SAME_SINGLE_ACCESS_RAM <= j[0];
      bt(br[j]);
    end
    $display("bit tests done");
    foreach (mr[j])
    begin
      SAME_SINGLE_ACCESS_RAM <= j[2];
      mv(mr[j]);
    end
    $display("move tests done");
    // a start held high while busy is ignored
    fork
      mv(mr[0]);
      begin
        @(posedge CLK_SYS iff BUSY);
        nd0 = ndone;
        START <= 1'b1;
        repeat (3) @(posedge CLK_SYS);
        START <= 1'b0;
      end
    join
    repeat (12) @(posedge CLK_SYS);
    chk("one_done", ndone - nd0, 1);
    $display("refusal test done");
    // reset in mid-run stops the move and frees the unit
    OP <= OP_BLOCK_MOVE_DATA_TO_DATA;
    {REPEATED, REPEAT_COUNT} <= {1'b1, 16'h0014};
    START <= 1'b1;
    @(posedge CLK_SYS);
    START <= 1'b0;
    repeat (8) @(posedge CLK_SYS);
    RESETN <= 1'b0;
    @(negedge CLK_SYS);
    chk("rst_out", {BUSY, INT_HOLD, MEM_WR, PC_WE}, 0);
    @(posedge CLK_SYS);
    RESETN <= 1'b1;
    repeat (3) @(posedge CLK_SYS);
    mv(mr[1]);
    $display("reset test done");
    end_sim();
  end

  // watchdog
  initial
  begin
    #200000;
    n_fail++;
    end_sim();
  end
endmodule

// ---- verif/btm_mem_model.sv ----
// program and data memory model with settable wait states
`timescale 1ns/1ps
module btm_mem_model
(
  input  wire logic        clk,
  input  wire logic        rd,
  input  wire logic        rd_prog,
  input  wire logic        wr,
  input  wire logic [15:0] addr,
  input  wire logic [15:0] wdata,
  input  wire logic [1:0]  waits,
  output logic             ready,
  output logic [15:0]      rdata
);
  logic [15:0] mem [logic [15:0]];
  logic [1:0]  cnt = 2'h0;
  logic [15:0] last = 16'h0000;
  // access ends after the wait states, on or off chip alike
  assign ready = (rd | rd_prog | wr) && (cnt == waits);
  // unwritten words follow the address; an idle bus shows the inverse of the last read word
  always_comb
    if ((rd | rd_prog) && ready)
      rdata = rd_prog ? (addr ^ 16'h5A5A) : (mem.exists(addr) ? mem[addr] : addr ^ 16'hC3A5);
    else
      rdata = ~last;
  // wait counter, read history and write storage
  always @(posedge clk)
  begin
    cnt <= ((rd | rd_prog | wr) && !ready) ? cnt + 2'h1 : 2'h0;
    if ((rd | rd_prog) && ready)
      last <= rdata;
    if (wr && ready)
      mem[addr] = wdata;
  end
endmodule
